// file: core/pixel_input_mux.v
// Purpose: two-to-one multiplexed pixel input front end of a video DAC
// Assumes: CLK_SYS is the pixel clock; all inputs synchronous to it
// Notes:   the converter itself sits outside; DAC_LEVEL is its input code
`timescale 1ns/1ps
`include "pixmux_consts.vh"

module pixel_input_mux #(
   parameter PIX_W      = `PIX_W,
   parameter LEVEL_W    = `LEVEL_W,
   parameter FIFO_DEPTH = `FIFO_DEPTH,
   parameter FIFO_AW    = `FIFO_AW
) (
   // clock and reset
   input  wire               CLK_SYS,
   input  wire               RST_N,
   // pixel source side
   input  wire [PIX_W-1:0]   EVEN_PIXEL_BUS,
   input  wire [PIX_W-1:0]   ODD_PIXEL_BUS,
   input  wire               BLANK,
   input  wire               PEDESTAL_FLOAT,
   // half-rate clock pins
   input  wire               HALF_RATE_CLOCK_IN,
   output reg                HALF_RATE_CLOCK_OUT_N,
   // converter side
   input  wire               DAC_HOLD,
   output reg  [LEVEL_W-1:0] DAC_LEVEL,
   output reg                PIXEL_VALID,
   output reg                ODD_SLOT,
   output reg                BLANK_ACTIVE,
   // status
   output reg                CAPTURE_DROP
);

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   wire                 capture_edge;
   wire                 cap_valid;
   wire                 cap_ready;
   wire [`PAIR_W-1:0]   cap_data;
   wire                 q_valid;
   wire                 q_ready;
   wire [`PAIR_W-1:0]   q_data;
   reg                  slot_r;
   reg                  slot_nxt;
   reg  [PIX_W-1:0]     odd_hold_r;
   reg  [PIX_W-1:0]     odd_hold_nxt;
   reg                  blank_hold_r;
   reg                  blank_hold_nxt;
   reg  [PIX_W-1:0]     code_nxt;
   reg                  blank_nxt;
   reg                  valid_nxt;
   reg                  pop;
   reg  [LEVEL_W-1:0]   level_nxt;
   reg  [LEVEL_W-1:0]   black_off;
   reg  [LEVEL_W-1:0]   code_ext;

   // ----------------------------------------------------------------------
   // slot states
   // ----------------------------------------------------------------------
   localparam [0:0] ST_EVEN = `SLOT_EVEN;
   localparam [0:0] ST_ODD  = `SLOT_ODD;

   // ----------------------------------------------------------------------
   // half-rate clock generator
   // ----------------------------------------------------------------------
   // the output is just the input retimed and inverted; looping it back
   // gives a toggle every pixel clock, so the divider needs no own state
   always @(posedge CLK_SYS) begin
      if (!RST_N) begin
         HALF_RATE_CLOCK_OUT_N <= `HALF_OUT_RST;
      end else begin
         HALF_RATE_CLOCK_OUT_N <= ~HALF_RATE_CLOCK_IN;
      end
   end

   // a falling edge of the output happens on the edge where it is high
   // and is about to load zero; the pair is taken at that same edge
   // period of the input is left to the system outside
   assign capture_edge = HALF_RATE_CLOCK_OUT_N
                       & HALF_RATE_CLOCK_IN
                       & RST_N;

   // ----------------------------------------------------------------------
   // capture of the pair
   // ----------------------------------------------------------------------
   assign cap_valid = capture_edge;
   // blank rides in the same word as its two pixels
   assign cap_data  = {BLANK, ODD_PIXEL_BUS, EVEN_PIXEL_BUS};

   // when the buffer is full the pair is lost and flagged; the source has
   // no ready pin, so stalling it is not possible
   always @(posedge CLK_SYS) begin
      if (!RST_N) begin
         CAPTURE_DROP <= 1'b0;
      end else begin
         CAPTURE_DROP <= cap_valid & ~cap_ready;
      end
   end

   pair_fifo #(
      .WIDTH (`PAIR_W),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_pair_fifo (
      .clk       (CLK_SYS),
      .rst_n     (RST_N),
      .in_valid  (cap_valid),
      .in_ready  (cap_ready),
      .in_data   (cap_data),
      .out_valid (q_valid),
      .out_ready (q_ready),
      .out_data  (q_data)
   );

   // ----------------------------------------------------------------------
   // serializer: even slot then odd slot
   // ----------------------------------------------------------------------
   // pops only in the even slot, so a pair is never split by the phase
   always @* begin
      slot_nxt       = slot_r;
      odd_hold_nxt   = odd_hold_r;
      blank_hold_nxt = blank_hold_r;
      code_nxt       = {PIX_W{1'b0}};
      blank_nxt      = 1'b1;
      valid_nxt      = 1'b0;
      pop            = 1'b0;
      case (slot_r)
         ST_EVEN: begin
            if (q_valid && !DAC_HOLD) begin
               pop            = 1'b1;
               code_nxt       = q_data[`EVEN_MSB:`EVEN_LSB];
               blank_nxt      = q_data[`BLANK_BIT];
               odd_hold_nxt   = q_data[`ODD_MSB:`ODD_LSB];
               blank_hold_nxt = q_data[`BLANK_BIT];
               valid_nxt      = 1'b1;
               slot_nxt       = ST_ODD;
            end
         end
         ST_ODD: begin
            if (!DAC_HOLD) begin
               code_nxt  = odd_hold_r;
               blank_nxt = blank_hold_r;
               valid_nxt = 1'b1;
               slot_nxt  = ST_EVEN;
            end else begin
               code_nxt  = odd_hold_r;
               blank_nxt = blank_hold_r;
            end
         end
         default: begin
            slot_nxt = ST_EVEN;
         end
      endcase
   end

   assign q_ready = pop;

   // ----------------------------------------------------------------------
   // level coding
   // ----------------------------------------------------------------------
   // three level steps per code; keeps the map linear without a multiplier
   always @* begin
      code_ext  = {{(LEVEL_W-PIX_W){1'b0}}, code_nxt};
      black_off = PEDESTAL_FLOAT ? `PED_OFFSET : `ZERO_OFFSET;
      if (blank_nxt) begin
         level_nxt = `BLANK_LEVEL;
      end else begin
         level_nxt = black_off + code_ext + {code_ext[LEVEL_W-2:0], 1'b0};
      end
   end

   // ----------------------------------------------------------------------
   // serializer state
   // ----------------------------------------------------------------------
   always @(posedge CLK_SYS) begin
      if (!RST_N) begin
         slot_r       <= ST_EVEN;
         odd_hold_r   <= {PIX_W{1'b0}};
         blank_hold_r <= 1'b1;
      end else begin
         slot_r       <= slot_nxt;
         odd_hold_r   <= odd_hold_nxt;
         blank_hold_r <= blank_hold_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // output registers
   // ----------------------------------------------------------------------
   // during a hold the last level stays, so the converter sees no glitch
   always @(posedge CLK_SYS) begin
      if (!RST_N) begin
         DAC_LEVEL    <= `BLANK_LEVEL;
         PIXEL_VALID  <= 1'b0;
         ODD_SLOT     <= 1'b0;
         BLANK_ACTIVE <= 1'b1;
      end else begin
         PIXEL_VALID  <= valid_nxt;
         if (!DAC_HOLD) begin
            DAC_LEVEL    <= level_nxt;
            ODD_SLOT     <= (slot_r == ST_ODD);
            BLANK_ACTIVE <= blank_nxt;
         end
      end
   end

endmodule // pixel_input_mux

// file: core/pixmux_consts.vh
// Purpose: shared constants of the two-to-one pixel input multiplexer
// Assumes: one 40 MHz pixel clock, synchronous active-low reset
// Notes:   levels are unsigned codes, blank at zero, white at the top
`ifndef PIXMUX_CONSTS_VH
`define PIXMUX_CONSTS_VH

// ----------------------------------------------------------------------
// captured pair layout
// ----------------------------------------------------------------------
`define PIX_W          8
`define PAIR_W         17
`define EVEN_LSB       0
`define EVEN_MSB       7
`define ODD_LSB        8
`define ODD_MSB        15
`define BLANK_BIT      16

// ----------------------------------------------------------------------
// output level coding
// ----------------------------------------------------------------------
`define LEVEL_W        10
`define BLANK_LEVEL    10'h000
`define PED_OFFSET     10'h03E
`define ZERO_OFFSET    10'h000

// ----------------------------------------------------------------------
// buffering and reset values
// ----------------------------------------------------------------------
`define FIFO_DEPTH     16
`define FIFO_AW        4
`define HALF_OUT_RST   1'b1
`define SLOT_EVEN      1'b0
`define SLOT_ODD       1'b1

`endif

// file: core/pair_fifo.v
// Purpose: synchronous first-in first-out buffer with valid/ready
// Assumes: one clock, synchronous active-low reset
// Notes:   first-word fall-through read; full and empty from a count
`timescale 1ns/1ps

module pair_fifo #(
   parameter WIDTH = 17,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   // clock and reset
   input  wire             clk,
   input  wire             rst_n,
   // filling side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // draining side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0]    wr_ptr_r;
   reg  [AW-1:0]    rd_ptr_r;
   reg  [AW:0]      count_r;
   wire             do_wr;
   wire             do_rd;

   // ----------------------------------------------------------------------
   // flags
   // ----------------------------------------------------------------------
   assign in_ready  = (count_r != DEPTH[AW:0]);
   assign out_valid = (count_r != {(AW+1){1'b0}});
   assign do_wr     = in_valid & in_ready;
   assign do_rd     = out_valid & out_ready;
   assign out_data  = mem[rd_ptr_r];

   // ----------------------------------------------------------------------
   // storage and pointers
   // ----------------------------------------------------------------------
   always @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r  <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                        : wr_ptr_r + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                        : rd_ptr_r + 1'b1;
         end
         if (do_wr && !do_rd) begin
            count_r <= count_r + 1'b1;
         end else if (do_rd && !do_wr) begin
            count_r <= count_r - 1'b1;
         end
      end
   end

endmodule // pair_fifo

// file: dv/pixel_source.sv
// Purpose: pixel source model for the pixel input mux
// Assumes: values change on the falling pixel clock edge
// Notes:   a new pair every cycle, so a late capture shows
`timescale 1ns/1ps
module pixel_source (
   // clock
   input  wire       clk,
   // pair and half-rate clock
   output reg  [7:0] even_pix,
   output reg  [7:0] odd_pix,
   output reg        blank,
   output reg        half_clk
);
   reg [31:0] r;
   initial begin
      even_pix = 8'h00;
      odd_pix  = 8'h00;
      blank    = 1'b0;
      half_clk = 1'b0;
   end
   always @(negedge clk) begin
      r = $urandom;
      even_pix <= (r[3:1] == 3'h0) ? {8{r[0]}} : r[15:8];
      odd_pix  <= (r[6:4] == 3'h0) ? {8{r[7]}} : r[23:16];
      blank    <= (r[26:24] == 3'h0);
      half_clk <= ~half_clk;
   end
endmodule // pixel_source

// file: dv/pixmux_checker.sv
// Purpose: port assertions of the pixel input mux
// Assumes: one clock, reset low
// Notes:   bound at the top module
`timescale 1ns/1ps
`include "pixmux_consts.vh"
module pixmux_checker (
   input wire       CLK_SYS,
   input wire       RST_N,
   input wire       PEDESTAL_FLOAT,
   input wire       HALF_RATE_CLOCK_IN,
   input wire       HALF_RATE_CLOCK_OUT_N,
   input wire       DAC_HOLD,
   input wire [9:0] DAC_LEVEL,
   input wire       PIXEL_VALID,
   input wire       ODD_SLOT,
   input wire       BLANK_ACTIVE,
   input wire       CAPTURE_DROP
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   wire [9:0] off = PEDESTAL_FLOAT ? `PED_OFFSET : `ZERO_OFFSET;
   wire [9:0] x3  = DAC_LEVEL - off;
   property p_half_inv;
      $past(RST_N) |-> HALF_RATE_CLOCK_OUT_N == !$past(HALF_RATE_CLOCK_IN);
   endproperty
   a_half_inv: assert property (p_half_inv) else $error("half out");
   property p_toggle;
      $past(RST_N) && $past(HALF_RATE_CLOCK_IN == HALF_RATE_CLOCK_OUT_N)
      |-> HALF_RATE_CLOCK_OUT_N != $past(HALF_RATE_CLOCK_OUT_N);
   endproperty
   a_toggle: assert property (p_toggle) else $error("no toggle");
   property p_pair;
      PIXEL_VALID && !ODD_SLOT && !DAC_HOLD |=> PIXEL_VALID && ODD_SLOT;
   endproperty
   a_pair: assert property (p_pair) else $error("odd late");
   property p_hold;
      DAC_HOLD |=> !PIXEL_VALID && $stable(DAC_LEVEL);
   endproperty
   a_hold: assert property (p_hold) else $error("hold moved");
   property p_blank_zero;
      BLANK_ACTIVE |-> DAC_LEVEL == `BLANK_LEVEL;
   endproperty
   a_blank_zero: assert property (p_blank_zero) else $error("blank lvl");
   property p_odd_blank;
      PIXEL_VALID && ODD_SLOT |-> BLANK_ACTIVE == $past(BLANK_ACTIVE);
   endproperty
   a_odd_blank: assert property (p_odd_blank) else $error("odd blank");
   property p_level;
      PIXEL_VALID && !BLANK_ACTIVE
      |-> DAC_LEVEL >= off && x3 % 3 == 0 && x3 <= 10'h2FD;
   endproperty
   a_level: assert property (p_level) else $error("level");
   property p_drop;
      CAPTURE_DROP |-> $past(HALF_RATE_CLOCK_IN & HALF_RATE_CLOCK_OUT_N)
         || $past(HALF_RATE_CLOCK_IN & HALF_RATE_CLOCK_OUT_N, 2);
   endproperty
   a_drop: assert property (p_drop) else $error("drop cause");
   c_drop: cover property (CAPTURE_DROP);
   c_blank: cover property (PIXEL_VALID && !ODD_SLOT && BLANK_ACTIVE);
   c_hold: cover property (PIXEL_VALID && !ODD_SLOT && DAC_HOLD);
endmodule // pixmux_checker
bind pixel_input_mux pixmux_checker u_chk (.CLK_SYS(CLK_SYS),
   .RST_N(RST_N), .PEDESTAL_FLOAT(PEDESTAL_FLOAT),
   .HALF_RATE_CLOCK_IN(HALF_RATE_CLOCK_IN), .DAC_HOLD(DAC_HOLD),
   .HALF_RATE_CLOCK_OUT_N(HALF_RATE_CLOCK_OUT_N), .DAC_LEVEL(DAC_LEVEL),
   .PIXEL_VALID(PIXEL_VALID), .ODD_SLOT(ODD_SLOT),
   .BLANK_ACTIVE(BLANK_ACTIVE), .CAPTURE_DROP(CAPTURE_DROP));

// file: dv/two_to_one_pixel_input_mux_tb.sv
// Purpose: self-checking bench of the pixel input mux
// Assumes: 40 MHz clock, inputs change on the falling edge
// Notes:   pedestal changes only while the buffer is drained
`timescale 1ns/1ps
`include "pixmux_consts.vh"
module two_to_one_pixel_input_mux_tb;
   reg         clk = 1'b0;
   reg         rst_n = 1'b0;
   reg         ped = 1'b0;
   reg         hold = 1'b0;
   reg         open_loop = 1'b0;
   reg         stall = 1'b0;
   reg         exp_odd = 1'b0;
   reg  [16:0] q[$];
   wire [7:0]  ev;
   wire [7:0]  od;
   wire [9:0]  level;
   wire        bl, half_src, out_n, pv, odd_slot, blank_act, drop;
   wire        half_in = open_loop ? (half_src & ~stall) : out_n;
   integer     failures = 0;
   integer     total_checks = 0;
   integer     cycles = 0;
   integer     occ = 0;
   reg         cap_prev = 1'b0;
   reg         exp_drop = 1'b0;
   always #12.5 clk = ~clk;
   pixel_source u_src (.clk(clk), .even_pix(ev), .odd_pix(od), .blank(bl),
      .half_clk(half_src));
   pixel_input_mux u_dut (.CLK_SYS(clk), .RST_N(rst_n),
      .EVEN_PIXEL_BUS(ev), .ODD_PIXEL_BUS(od), .BLANK(bl),
      .PEDESTAL_FLOAT(ped), .HALF_RATE_CLOCK_IN(half_in),
      .HALF_RATE_CLOCK_OUT_N(out_n), .DAC_HOLD(hold), .DAC_LEVEL(level),
      .PIXEL_VALID(pv), .ODD_SLOT(odd_slot), .BLANK_ACTIVE(blank_act),
      .CAPTURE_DROP(drop));
   function [9:0] exp_level(input [16:0] p, input sel, input pf);
      reg [7:0] c;
      begin
         c = sel ? p[15:8] : p[7:0];
         exp_level = p[16] ? `BLANK_LEVEL
                   : (pf ? `PED_OFFSET : `ZERO_OFFSET) + 10'd3 * c;
      end
   endfunction
   task check(input [9:0] seen, input [9:0] exp, input [8*6-1:0] what);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED %0s exp %h seen %h", what, exp, seen);
         end
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d failures %0d", total_checks, failures);
         if (failures == 0 && total_checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // scoreboard: pairs captured on the design's own capture edges
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 8000) begin
         failures = failures + 1;
         finish_test;
      end
      // buffer occupancy model: a pair is lost only when 16 are waiting
      if (rst_n) begin
         exp_drop = cap_prev && occ == `FIFO_DEPTH;
         check({9'h0, drop}, {9'h0, exp_drop}, "drop");
         occ = occ + (cap_prev && !exp_drop) - (pv === 1'b1 && !odd_slot);
         cap_prev = out_n === 1'b1 && half_in === 1'b1;
      end
      if (rst_n && drop === 1'b1 && q.size() > 0)
         void'(q.pop_back());
      if (rst_n && pv === 1'b1) begin
         check({9'h0, q.size() > 0}, 10'h1, "queue");
         if (q.size() > 0) begin
            check({9'h0, odd_slot}, {9'h0, exp_odd}, "slot");
            check({9'h0, blank_act}, {9'h0, q[0][16]}, "blank");
            check(level, exp_level(q[0], exp_odd, ped), "level");
            if (exp_odd)
               void'(q.pop_front());
            exp_odd = ~exp_odd;
         end
      end
      if (rst_n && out_n === 1'b1 && half_in === 1'b1)
         q.push_back({bl, od, ev});
   end
   // drain with no captures, then run one mode
   task run(input pf, input op, input integer pct, input integer n);
      integer i;
      begin
         hold = 1'b0;
         stall = 1'b1;
         open_loop = 1'b1;
         repeat (50) @(negedge clk);
         check(q.size(), 10'h0, "drain");
         ped = pf;
         open_loop = op;
         stall = 1'b0;
         for (i = 0; i < n; i = i + 1) begin
            @(negedge clk);
            hold = ($urandom % 100) < pct;
         end
      end
   endtask
   initial begin
      void'($urandom(64963));
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      run(1'b0, 1'b0, 0, 400);
      run(1'b1, 1'b0, 40, 600);
      run(1'b0, 1'b0, 90, 500); // hold outruns output: buffer overflows
      run(1'b1, 1'b1, 20, 600);
      run(1'b0, 1'b1, 0, 300);
      run(1'b0, 1'b0, 0, 0);
      finish_test;
   end
endmodule // two_to_one_pixel_input_mux_tb
